// ===== bench/fcu_array_model.sv
// Behavioural flash array behind the command unit.
// Assumes one word slot per even address in the low 128 bytes.
`timescale 1ns/1ns
`default_nettype none
module fcu_array_model
	import fcu_pkg::*;
(
	// Clock
	input wire logic i_core_clk,
	// Requests
	input wire logic i_op,
	input wire logic i_erase,
	input wire fcu_word_t i_word,
	input wire logic [15:0] i_src_addr,
	input wire logic i_slow,
	input wire logic i_fail,
	// Answers
	output logic o_done,
	output logic o_ok,
	output logic [15:0] o_rdata,
	output logic [15:0] o_src_rdata
);
	logic [15:0] mem [0:63];
	logic [3:0] cnt;
	logic pend;
	logic erase_r;
	fcu_word_t word_r;
	initial begin
		o_done = 1'b0;
		pend = 1'b0;
		cnt = 4'h0;
		foreach (mem[k]) mem[k] = 16'hffff;
	end
	always @(posedge i_core_clk) begin
		o_done <= 1'b0;
		if (i_op) begin
			pend <= 1'b1;
			cnt <= i_slow ? 4'h9 : 4'h1;
			erase_r <= i_erase;
			word_r <= i_word;
		end else if (pend && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else if (pend) begin
			pend <= 1'b0;
			o_done <= 1'b1;
			// A failed verify leaves the cells as they were
			if (!i_fail && erase_r) begin
				foreach (mem[k]) mem[k] <= 16'hffff;
			end else if (!i_fail) begin
				mem[word_r.addr[6:1]] <= word_r.data;
			end
		end
	end
	// Verify flag is garbage outside the done cycle
	assign o_ok = o_done ? !i_fail : cnt[0];
	assign o_rdata = mem[i_word.addr[6:1]];
	assign o_src_rdata = i_src_addr ^ 16'h5a5a;
endmodule
`default_nettype wire

// ===== bench/fcu_flash_cmd_monitor.sv
// Port checker for the flash command unit.
// Assumes it is bound onto fcu_flash_cmd; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module fcu_flash_cmd_monitor
	import fcu_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Watched ports
	input wire logic i_wr_valid,
	input wire logic i_wr_indirect,
	input wire logic [16:0] i_wr_addr,
	input wire logic i_extended_segment_prefix_active,
	input wire fcu_regs_t i_regs,
	input wire logic i_rd_valid,
	input wire logic [16:0] i_rd_addr,
	input wire logic i_fetch_from_flash,
	input wire logic i_arr_done,
	input wire logic i_arr_verify_ok,
	input wire logic o_arr_op,
	input wire logic o_arr_erase,
	input wire fcu_regs_t o_result,
	input wire logic o_result_valid,
	input wire logic o_busy,
	input wire logic o_irq_block,
	input wire logic o_protect_active,
	input wire logic o_rd_allow
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic bad_cmd;
	assign bad_cmd = !(i_regs.r0[15:4] inside {12'h55a, 12'hdd4, 12'haa5})
		&& !(i_regs.r0 inside {16'heeee, 16'h7777});
	sequence s_arm;
		i_wr_valid && !i_wr_indirect && i_extended_segment_prefix_active && !o_busy && i_wr_addr == 17'h18000;
	endsequence
	sequence s_trig_bad;
		s_arm ##1 (i_wr_valid && i_wr_indirect && i_wr_addr == 17'h18000 && bad_cmd);
	endsequence
	a_bad_cmd_code: assert property (
		s_trig_bad |-> ##3 (o_result_valid && o_result.r0 == 16'h00ff))
		else $error("bad command not answered with ff");
	a_reject_no_op: assert property (s_trig_bad |-> !o_arr_op [*4])
		else $error("array touched by rejected command");
	a_op_busy: assert property (o_arr_op |-> o_busy)
		else $error("array started while kernel idle");
	a_valid_pulse: assert property (o_result_valid |=> !o_result_valid)
		else $error("result valid longer than one cycle");
	a_result_hold: assert property (!o_result_valid |-> $stable(o_result))
		else $error("result changed without valid");
	a_code_known: assert property (
		o_result_valid |-> o_result.r0 inside {[16'h0000:16'h000a], 16'h00ff})
		else $error("result code outside the set");
	a_prog_fail: assert property (
		i_arr_done && !i_arr_verify_ok && !o_arr_erase
		|-> ##[2:5] (o_result_valid && o_result.r0 == 16'h0003))
		else $error("program verify failure not reported");
	a_erase_fail: assert property (
		i_arr_done && !i_arr_verify_ok && o_arr_erase
		|-> ##[0:4] (o_result_valid && o_result.r0 == 16'h0008))
		else $error("erase verify failure not reported");
	a_read_deny: assert property (
		i_rd_valid && o_protect_active && !i_fetch_from_flash && i_rd_addr >= 17'h18000
		|-> !o_rd_allow)
		else $error("protected read allowed");
	a_read_open: assert property (!o_protect_active |-> o_rd_allow)
		else $error("read denied while unprotected");
	a_irq_lock: assert property (i_extended_segment_prefix_active && i_wr_valid |-> o_irq_block)
		else $error("interrupts open during unlock");
endmodule
`default_nettype wire

// ===== bench/fcu_flash_cmd_tb_top.sv
// Self-checking bench for the flash command unit.
// Assumes the checker and array model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module fcu_flash_cmd_tb_top
	import fcu_pkg::*;
;
	localparam logic [15:0] KREV = 16'h0a0b; // arbitrary value
	localparam logic [15:0] ID_LO = 16'h2468; // arbitrary value
	localparam logic [15:0] ID_HI = 16'h1357; // arbitrary value
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_external_access_pin_n = 1'b1;
	logic i_vpp_present = 1'b1, i_protection_otp_bit = 1'b0, i_syscfg_we = 1'b0;
	logic i_segment_map_wr = 1'b0, i_segmentation_disable_wr = 1'b0, i_end_of_init = 1'b0;
	logic i_wr_valid = 1'b0, i_wr_indirect = 1'b0, i_extended_segment_prefix_active = 1'b0;
	logic [16:0] i_wr_addr = 17'h00000, i_rd_addr = 17'h00000;
	logic [15:0] i_wr_data = 16'h0000, i_stack_pointer = 16'h0200;
	logic [15:0] i_stack_overflow_limit = 16'h0100, i_arr_rdata, i_src_rdata, o_src_addr;
	logic i_fetch_from_flash = 1'b0, i_rd_valid = 1'b0, slow = 1'b0, fail = 1'b0;
	fcu_regs_t i_regs = '0, o_result;
	fcu_word_t o_arr_word;
	logic [1:0] o_arr_bank;
	logic o_arr_op, o_arr_erase, i_arr_done, i_arr_verify_ok, o_result_valid, o_busy;
	logic o_irq_block, o_flash_enable_bit, o_flash_segment_map_bit;
	logic o_segmentation_disable_bit, o_protect_active, o_rd_allow, got;
	int fail_count = 0, cmp_count = 0;
	fcu_regs_t tab [10] = '{
		'{16'h1230, 16'h8000, 16'h0000, 16'h0000, 16'h0032},
		'{16'h55a1, 16'h8000, 16'h0000, 16'h0000, 16'h0009},
		'{16'h55a1, 16'h8000, 16'h0000, 16'h0000, 16'h03e9},
		'{16'h55a1, 16'h8001, 16'h0000, 16'h0000, 16'h0032},
		'{16'h55a2, 16'h8000, 16'h0000, 16'h0000, 16'h0032},
		'{16'heeee, 16'h5555, 16'h0001, 16'h0002, 16'h0032},
		'{16'heeee, 16'h5555, 16'h0004, 16'h0004, 16'h0032},
		'{16'haa51, 16'h8000, 16'hc002, 16'h0100, 16'h0032},
		'{16'h7777, 16'h0000, 16'h0000, 16'h0000, 16'h000a},
		'{16'h7777, 16'h0000, 16'h0000, 16'h0000, 16'h03e8}};
	logic [15:0] codes [10] = '{16'h00ff, 16'h0005, 16'h0005, 16'h0004, 16'h0004,
		16'h0007, 16'h0007, 16'h000a, 16'h0000, 16'h0000};
	always #2 i_core_clk = ~i_core_clk;
	fcu_flash_cmd #(.KERNEL_REVISION(KREV), .CIRCUIT_ID_LO(ID_LO), .CIRCUIT_ID_HI(ID_HI)) dut_u (
		.i_core_clk, .i_rst, .i_external_access_pin_n, .i_vpp_present, .i_protection_otp_bit,
		.i_syscfg_we, .i_segment_map_wr, .i_segmentation_disable_wr, .i_end_of_init,
		.i_wr_valid, .i_wr_indirect, .i_wr_addr, .i_wr_data, .i_extended_segment_prefix_active,
		.i_fetch_from_flash, .i_rd_valid, .i_rd_addr, .i_regs, .i_stack_pointer,
		.i_stack_overflow_limit, .o_arr_op, .o_arr_erase, .o_arr_word, .o_arr_bank,
		.i_arr_done, .i_arr_verify_ok, .i_arr_rdata, .i_src_rdata, .o_src_addr, .o_result,
		.o_result_valid, .o_busy, .o_irq_block, .o_flash_enable_bit, .o_flash_segment_map_bit,
		.o_segmentation_disable_bit, .o_protect_active, .o_rd_allow);
	fcu_array_model arr_u (.i_core_clk, .i_op(o_arr_op), .i_erase(o_arr_erase),
		.i_word(o_arr_word), .i_src_addr(o_src_addr), .i_slow(slow), .i_fail(fail),
		.o_done(i_arr_done), .o_ok(i_arr_verify_ok), .o_rdata(i_arr_rdata),
		.o_src_rdata(i_src_rdata));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			fail_count++;
		end
	endtask
	task automatic do_reset();
		i_rst <= 1'b1;
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		#1;
	endtask
	// Direct write arms, indirect write to the same address triggers
	task automatic cmd(input fcu_regs_t r, input logic spoil);
		int n;
		@(posedge i_core_clk);
		i_regs <= r;
		i_extended_segment_prefix_active <= 1'b1;
		i_wr_valid <= 1'b1;
		i_wr_indirect <= 1'b0;
		i_wr_addr <= 17'h18000;
		i_wr_data <= 16'h8000;
		if (spoil) begin
			@(posedge i_core_clk);
			i_wr_addr <= 17'h18002;
		end
		@(posedge i_core_clk);
		i_wr_indirect <= 1'b1;
		i_wr_addr <= 17'h18000;
		@(posedge i_core_clk);
		i_wr_valid <= 1'b0;
		i_extended_segment_prefix_active <= 1'b0;
		n = 0;
		got = 1'b0;
		while (n < 60 && !got) begin
			@(posedge i_core_clk);
			#1;
			got = (o_result_valid === 1'b1);
			n++;
		end
	endtask
	task automatic res(input fcu_regs_t r, input logic [15:0] code);
		cmd(r, 1'b0);
		chk(16'(got), 16'h0001);
		chk(o_result.r0, code);
	endtask
	task automatic test_done();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		test_done();
	end
	initial begin
		do_reset();
		chk(16'({o_flash_enable_bit, o_protect_active, o_segmentation_disable_bit}), 16'h0005);
		res('{16'h55a1, 16'h8000, 16'h1111, 16'h0000, 16'h0032}, 16'h0000);
		chk(o_result.r1, 16'h8000);
		chk(o_result.r2, 16'h1111);
		chk(o_result.r3, 16'hffff);
		slow <= 1'b1;
		res('{16'hdd41, 16'h8000, 16'h3456, 16'h4567, 16'h0032}, 16'h0000);
		chk(o_result.r2, 16'h3456);
		chk(o_result.r3, 16'h4567);
		res('{16'heeee, 16'h5555, 16'h0001, 16'h0001, 16'h0032}, 16'h0000);
		chk(16'(o_arr_bank), 16'h0001);
		slow <= 1'b0;
		res('{16'haa51, 16'h8000, 16'h8004, 16'h0100, 16'h0032}, 16'h0000);
		chk(o_result.r1, 16'h8004);
		for (int k = 0; k < 10; k++) begin
			res(tab[k], codes[k]);
		end
		chk(o_result.r1, KREV);
		chk(o_result.r2, ID_LO);
		chk(o_result.r3, ID_HI);
		chk(o_result.r4, 16'h03e8);
		cmd(tab[9], 1'b1);
		chk(16'(got), 16'h0000);
		i_stack_pointer <= 16'h015a;
		res(tab[1] | 80'h0000_0000_0000_0000_0029, 16'h0006);
		i_stack_pointer <= 16'h0200;
		i_vpp_present <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		res(tab[3], 16'h0002);
		i_vpp_present <= 1'b1;
		fail <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		res('{16'h55a1, 16'h8000, 16'h2222, 16'h0000, 16'h0032}, 16'h0003);
		res('{16'heeee, 16'h5555, 16'h0001, 16'h0001, 16'h0032}, 16'h0008);
		fail <= 1'b0;
		i_syscfg_we <= 1'b1;
		i_segment_map_wr <= 1'b1;
		@(posedge i_core_clk);
		i_syscfg_we <= 1'b0;
		i_end_of_init <= 1'b1;
		@(posedge i_core_clk);
		i_end_of_init <= 1'b0;
		i_syscfg_we <= 1'b1;
		i_segment_map_wr <= 1'b0;
		i_segmentation_disable_wr <= 1'b1;
		@(posedge i_core_clk);
		i_syscfg_we <= 1'b0;
		@(posedge i_core_clk);
		#1;
		chk(16'({o_flash_segment_map_bit, o_segmentation_disable_bit}), 16'h0002);
		i_external_access_pin_n <= 1'b0;
		i_protection_otp_bit <= 1'b1;
		do_reset();
		chk(16'({o_flash_enable_bit, o_protect_active}), 16'h0001);
		i_rd_valid <= 1'b1;
		i_rd_addr <= 17'h18000;
		@(posedge i_core_clk);
		#1;
		chk(16'(o_rd_allow), 16'h0000);
		@(posedge i_core_clk);
		i_fetch_from_flash <= 1'b1;
		#1;
		chk(16'(o_rd_allow), 16'h0001);
		res(tab[3], 16'h0001);
		test_done();
	end
endmodule
bind fcu_flash_cmd fcu_flash_cmd_monitor mon_u (.i_core_clk, .i_rst, .i_wr_valid,
	.i_wr_indirect, .i_wr_addr, .i_extended_segment_prefix_active, .i_regs, .i_rd_valid, .i_rd_addr,
	.i_fetch_from_flash, .i_arr_done, .i_arr_verify_ok, .o_arr_op, .o_arr_erase,
	.o_result, .o_result_valid, .o_busy, .o_irq_block, .o_protect_active, .o_rd_allow);
`default_nettype wire

// ===== verilog/fcu_flash_cmd.sv
// Flash command unit: unlock detection, parameter checks, kernel sequencing,
// configuration at reset and read protection.
// Assumes the CPU presents its bus writes, working registers and fetch origin
// on the same clock; the array behind the op/done ports does pulse timing.
//
// What this block does
// - Interrupts, event transfers and class A traps blocked during unlock.
// - Result in R0: 00h ok, 01h enable clear, 02h no programming voltage.
// - 03h on program verify failure, 08h on erase verify failure.
// - 04h when target offset is odd or outside flash.
// - 05h when CPU period is outside 10 to 1000 ns.
// - 06h unless stack pointer exceeds overflow limit plus 90.
// - 07h on bad bank number, FFh on unknown command.
// - Block programming: 09h bad source, 0Ah bad word count.
// - Single/double: kept, read back target and target plus 2.
// - Block: holds last or failing offset.
// - Erase: R0 holds result, ..undefined.
// - Status: kernel revision, circuit identifiers.
// - Flash enable bit is sampled from the external access pin at reset.
// - Remapping moves only the first 32 KB; 18000h..1FFFFh stay fixed.
// - Protection denies operand reads except from flash code, refuses program/erase.
// - One-time protection bit set to 1 enables protection after reset.
// - Protection lifts only after zeros written to all even addresses from flash.
`timescale 1ns/1ns
`default_nettype none
`include "fcu_regs.svh"

module fcu_flash_cmd
	import fcu_pkg::*;
#(
	parameter logic [15:0] KERNEL_REVISION = 16'h0001, // arbitrary value
	parameter logic [15:0] CIRCUIT_ID_LO = 16'h1234,   // arbitrary value
	parameter logic [15:0] CIRCUIT_ID_HI = 16'h5678    // arbitrary value
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Pins and straps
	input wire logic i_external_access_pin_n,
	input wire logic i_vpp_present,
	input wire logic i_protection_otp_bit,
	// System configuration writes
	input wire logic i_syscfg_we,
	input wire logic i_segment_map_wr,
	input wire logic i_segmentation_disable_wr,
	input wire logic i_end_of_init,
	// CPU data bus writes and reads
	input wire logic i_wr_valid,
	input wire logic i_wr_indirect,
	input wire logic [16:0] i_wr_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_extended_segment_prefix_active,
	input wire logic i_fetch_from_flash,
	input wire logic i_rd_valid,
	input wire logic [16:0] i_rd_addr,
	// Working registers and stack
	input wire fcu_regs_t i_regs,
	input wire logic [15:0] i_stack_pointer,
	input wire logic [15:0] i_stack_overflow_limit,
	// Array side
	output logic o_arr_op,
	output logic o_arr_erase,
	output fcu_word_t o_arr_word,
	output logic [1:0] o_arr_bank,
	input wire logic i_arr_done,
	input wire logic i_arr_verify_ok,
	input wire logic [15:0] i_arr_rdata,
	input wire logic [15:0] i_src_rdata,
	output logic [15:0] o_src_addr,
	// Results and status
	output fcu_regs_t o_result,
	output logic o_result_valid,
	output logic o_busy,
	output logic o_irq_block,
	output logic o_flash_enable_bit,
	output logic o_flash_segment_map_bit,
	output logic o_segmentation_disable_bit,
	output logic o_protect_active,
	output logic o_rd_allow
);

	typedef enum {FCU_IDLE, FCU_ARMED, FCU_CHECK, FCU_PROG, FCU_WAIT, FCU_READ1,
		FCU_READ2, FCU_ERASE, FCU_DONE} fcu_state_t;

	fcu_state_t state_r;
	fcu_regs_t cmd_r;
	fcu_regs_t res_r;
	logic [16:0] unlock_target_address_r;
	logic [15:0] offset_r;
	logic [15:0] src_r;
	logic [3:0] seg_r;
	logic [1:0] word_idx_r;
	logic [7:0] code_nxt;
	logic ea_s1_r, ea_s2_r, vpp_s1_r, vpp_s2_r;
	logic init_done_r;
	logic strap_pending_r;
	logic [15:0] clr_next_r;
	logic clr_run_r;
	logic [16:0] seg_base;
	logic [15:0] span;
	logic in_flash;
	logic unlock_hit;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		ea_s1_r <= i_external_access_pin_n;
		ea_s2_r <= ea_s1_r;
		vpp_s1_r <= i_vpp_present;
		vpp_s2_r <= vpp_s1_r;
	end

	// ------------------------------------------------------------
	// System configuration
	// ------------------------------------------------------------
	// Strap is caught after release, once the synchroniser holds a valid level
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			strap_pending_r <= 1'b1;
			o_flash_enable_bit <= 1'b0;
			o_flash_segment_map_bit <= 1'b0;
			o_segmentation_disable_bit <= 1'b1;
			init_done_r <= 1'b0;
		end else begin
			if (strap_pending_r) begin
				strap_pending_r <= 1'b0;
				o_flash_enable_bit <= ea_s2_r;
			end
			if (i_end_of_init)
				init_done_r <= 1'b1;
			// Mapping is frozen once initialisation ends
			if (i_syscfg_we && !init_done_r) begin
				o_flash_segment_map_bit <= i_segment_map_wr;
				o_segmentation_disable_bit <= i_segmentation_disable_wr;
			end
		end
	end

	// Only the first 32 KB follows the map bit; the rest is fixed
	always_comb begin
		seg_base = o_flash_segment_map_bit ? `FCU_SEG1_BASE : 17'h00000;
		in_flash = (
			(i_wr_addr >= seg_base && i_wr_addr < seg_base + `FCU_REMAP_SIZE) ||
			(i_wr_addr >= `FCU_FIXED_LO && i_wr_addr <= `FCU_FIXED_HI));
	end

	// ------------------------------------------------------------
	// Read protection
	// ------------------------------------------------------------
	// Clear walks even offsets in order; an out-of-order or nonzero write from flash code restarts, other writes leave it
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_protect_active <= 1'b0;
			clr_next_r <= 16'h0000;
			clr_run_r <= 1'b0;
		end else if (strap_pending_r) begin
			o_protect_active <= i_protection_otp_bit;
			clr_next_r <= 16'h0000;
			clr_run_r <= 1'b0;
		end else if (o_protect_active && i_wr_valid && in_flash) begin
			if (i_fetch_from_flash && i_wr_data == 16'h0000 && !i_wr_addr[0]
					&& i_wr_addr[15:0] == clr_next_r) begin
				clr_next_r <= clr_next_r + 16'h0002;
				clr_run_r <= 1'b1;
				if (clr_next_r == 16'hfffe)
					o_protect_active <= 1'b0;
			end else if (!i_fetch_from_flash) begin
				clr_run_r <= clr_run_r;
			end else begin
				clr_next_r <= 16'h0000;
				clr_run_r <= 1'b0;
			end
		end
	end

	assign o_rd_allow = !i_rd_valid || !o_protect_active || i_fetch_from_flash
		|| !(i_rd_addr >= `FCU_FIXED_LO || (i_rd_addr >= seg_base
		&& i_rd_addr < seg_base + `FCU_REMAP_SIZE));

	// ------------------------------------------------------------
	// Unlock detection
	// ------------------------------------------------------------
	// Direct write arms; the very next write must be indirect to the same address
	assign unlock_hit = i_wr_valid && i_wr_indirect && state_r == FCU_ARMED
		&& i_wr_addr == unlock_target_address_r;
	assign o_irq_block = i_extended_segment_prefix_active && (state_r == FCU_ARMED || i_wr_valid);
	assign o_busy = state_r != FCU_IDLE && state_r != FCU_ARMED;

	// ------------------------------------------------------------
	// Parameter checks, all before the array is touched
	// ------------------------------------------------------------
	always_comb begin
		span = cmd_r.r2 - cmd_r.r1;
		code_nxt = `FCU_RC_OK;
		if (cmd_r.r0 == `FCU_CMD_STATUS)
			code_nxt = `FCU_RC_OK;
		else if (cmd_r.r0[15:4] != `FCU_CMD_SINGLE && cmd_r.r0[15:4] != `FCU_CMD_DOUBLE
				&& cmd_r.r0[15:4] != `FCU_CMD_BLOCK && cmd_r.r0 != `FCU_CMD_ERASE)
			code_nxt = `FCU_RC_BAD_CMD;
		else if (!o_flash_enable_bit)
			code_nxt = `FCU_RC_NO_ENABLE;
		else if (!vpp_s2_r)
			code_nxt = `FCU_RC_NO_VPP;
		else if (o_protect_active)
			code_nxt = `FCU_RC_BAD_CMD;
		else if (cmd_r.r4 < `FCU_PERIOD_MIN_NS || cmd_r.r4 > `FCU_PERIOD_MAX_NS)
			code_nxt = `FCU_RC_BAD_PERIOD;
		else if (i_stack_pointer <= i_stack_overflow_limit + `FCU_STACK_MARGIN)
			code_nxt = `FCU_RC_STACK;
		else if (cmd_r.r0 == `FCU_CMD_ERASE) begin
			if (cmd_r.r1 != `FCU_ERASE_KEY)
				code_nxt = `FCU_RC_BAD_CMD;
			else if (cmd_r.r2 != cmd_r.r3 || cmd_r.r2 >= `FCU_BANK_COUNT)
				code_nxt = `FCU_RC_BAD_BANK;
		end else if (cmd_r.r0[3:0] >= `FCU_SEG_COUNT || cmd_r.r1[0])
			code_nxt = `FCU_RC_BAD_ADDR;
		else if (cmd_r.r0[15:4] == `FCU_CMD_BLOCK) begin
			if (cmd_r.r2[0] || cmd_r.r2 < cmd_r.r1)
				code_nxt = `FCU_RC_BAD_ADDR;
			else if (cmd_r.r3[0] || cmd_r.r3 >= `FCU_PAGE_SPAN)
				code_nxt = `FCU_RC_BAD_SRC;
			else if (span >= `FCU_PAGE_SPAN || cmd_r.r3 + span >= `FCU_PAGE_SPAN)
				code_nxt = `FCU_RC_BAD_COUNT;
		end
	end

	// ------------------------------------------------------------
	// Kernel sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_r <= FCU_IDLE;
			cmd_r <= '0;
			res_r <= '0;
			unlock_target_address_r <= 17'h00000;
			offset_r <= 16'h0000;
			src_r <= 16'h0000;
			seg_r <= 4'h0;
			word_idx_r <= 2'h0;
			o_arr_op <= 1'b0;
			o_arr_erase <= 1'b0;
			o_arr_word <= '0;
			o_arr_bank <= 2'h0;
			o_result <= '0;
			o_result_valid <= 1'b0;
		end else begin
			o_arr_op <= 1'b0;
			o_result_valid <= 1'b0;
			case (state_r)
				FCU_IDLE: begin
					if (i_wr_valid && !i_wr_indirect && i_extended_segment_prefix_active && in_flash
							&& !i_wr_addr[0]) begin
						unlock_target_address_r <= i_wr_addr;
						state_r <= FCU_ARMED;
					end
				end
				FCU_ARMED: begin
					if (unlock_hit) begin
						cmd_r <= i_regs;
						state_r <= FCU_CHECK;
					end else if (i_wr_valid) begin
						state_r <= FCU_IDLE;
					end
				end
				FCU_CHECK: begin
					res_r <= cmd_r;
					res_r.r0 <= {8'h00, code_nxt};
					seg_r <= cmd_r.r0[3:0];
					offset_r <= cmd_r.r1;
					src_r <= cmd_r.r3;
					word_idx_r <= 2'h0;
					if (code_nxt != `FCU_RC_OK)
						state_r <= FCU_DONE;
					else if (cmd_r.r0 == `FCU_CMD_STATUS) begin
						res_r.r1 <= KERNEL_REVISION;
						res_r.r2 <= CIRCUIT_ID_LO;
						res_r.r3 <= CIRCUIT_ID_HI;
						state_r <= FCU_DONE;
					end else if (cmd_r.r0 == `FCU_CMD_ERASE) begin
						o_arr_bank <= cmd_r.r2[1:0];
						o_arr_erase <= 1'b1;
						o_arr_op <= 1'b1;
						state_r <= FCU_ERASE;
					end else
						state_r <= FCU_PROG;
				end
				FCU_PROG: begin
					o_arr_erase <= 1'b0;
					o_arr_word.addr <= {seg_r[0], offset_r};
					if (cmd_r.r0[15:4] == `FCU_CMD_BLOCK)
						o_arr_word.data <= i_src_rdata;
					else
						o_arr_word.data <= word_idx_r == 2'h0 ? cmd_r.r2 : cmd_r.r3;
					o_arr_op <= 1'b1;
					state_r <= FCU_WAIT;
				end
				FCU_WAIT: begin
					if (i_arr_done) begin
						if (!i_arr_verify_ok) begin
							res_r.r0 <= {8'h00, `FCU_RC_PROG_FAIL};
							res_r.r1 <= offset_r;
							state_r <= cmd_r.r0[15:4] == `FCU_CMD_BLOCK ? FCU_DONE : FCU_READ1;
						end else if (cmd_r.r0[15:4] == `FCU_CMD_BLOCK) begin
							res_r.r1 <= offset_r;
							if (offset_r == cmd_r.r2)
								state_r <= FCU_DONE;
							else begin
								offset_r <= offset_r + 16'h0002;
								src_r <= src_r + 16'h0002;
								state_r <= FCU_PROG;
							end
						end else if (cmd_r.r0[15:4] == `FCU_CMD_DOUBLE && word_idx_r == 2'h0) begin
							word_idx_r <= 2'h1;
							offset_r <= offset_r + 16'h0002;
							state_r <= FCU_PROG;
						end else
							state_r <= FCU_READ1;
					end
				end
				FCU_READ1: begin
					o_arr_word.addr <= {seg_r[0], cmd_r.r1};
					state_r <= FCU_READ2;
				end
				FCU_READ2: begin
					// Read-back needs one cycle per word from the array port
					if (word_idx_r != 2'h3) begin
						res_r.r2 <= i_arr_rdata;
						o_arr_word.addr <= {seg_r[0], cmd_r.r1 + 16'h0002};
						word_idx_r <= 2'h3;
					end else begin
						res_r.r3 <= i_arr_rdata;
						res_r.r1 <= cmd_r.r1;
						state_r <= FCU_DONE;
					end
				end
				FCU_ERASE: begin
					if (i_arr_done) begin
						o_arr_erase <= 1'b0;
						if (!i_arr_verify_ok)
							res_r.r0 <= {8'h00, `FCU_RC_ERASE_FAIL};
						state_r <= FCU_DONE;
					end
				end
				FCU_DONE: begin
					o_result <= res_r;
					o_result_valid <= 1'b1;
					state_r <= FCU_IDLE;
				end
				default: state_r <= FCU_IDLE;
			endcase
		end
	end

	assign o_src_addr = src_r;

endmodule

`default_nettype wire

// ===== verilog/fcu_pkg.sv
// Types shared by the flash command unit.
// Assumes fcu_regs.svh is on the include path.
`include "fcu_regs.svh"

package fcu_pkg;

	typedef struct packed {
		logic [15:0] r0;
		logic [15:0] r1;
		logic [15:0] r2;
		logic [15:0] r3;
		logic [15:0] r4;
	} fcu_regs_t;

	typedef struct packed {
		logic [16:0] addr;
		logic [15:0] data;
	} fcu_word_t;

endpackage

// ===== verilog/fcu_regs.svh
// Constants of the flash command unit: result codes, command words, limits.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FCU_REGS_SVH
`define FCU_REGS_SVH

`define FCU_RC_OK          8'h00
`define FCU_RC_NO_ENABLE   8'h01
`define FCU_RC_NO_VPP      8'h02
`define FCU_RC_PROG_FAIL   8'h03
`define FCU_RC_BAD_ADDR    8'h04
`define FCU_RC_BAD_PERIOD  8'h05
`define FCU_RC_STACK       8'h06
`define FCU_RC_BAD_BANK    8'h07
`define FCU_RC_ERASE_FAIL  8'h08
`define FCU_RC_BAD_SRC     8'h09
`define FCU_RC_BAD_COUNT   8'h0a
`define FCU_RC_BAD_CMD     8'hff

`define FCU_CMD_SINGLE     12'h55a
`define FCU_CMD_DOUBLE     12'hdd4
`define FCU_CMD_BLOCK      12'haa5
`define FCU_CMD_ERASE      16'heeee
`define FCU_CMD_STATUS     16'h7777
`define FCU_ERASE_KEY      16'h5555

`define FCU_PERIOD_MIN_NS  16'h000a
`define FCU_PERIOD_MAX_NS  16'h03e8
`define FCU_STACK_MARGIN   16'h005a
`define FCU_PAGE_SPAN      16'h4000
`define FCU_BANK_COUNT     16'h0004
`define FCU_SEG_COUNT      4'h2
`define FCU_FIXED_LO       17'h18000
`define FCU_FIXED_HI       17'h1ffff
`define FCU_REMAP_SIZE     17'h08000
`define FCU_SEG1_BASE      17'h10000

`endif
